// File: src/jkg_pkg.sv
// shared constants and types for the gated j-k flip-flop
package jkg_pkg;

  // ****************************************
  // gate widths and variant selection
  // ****************************************
  localparam int unsigned GATE_W = 3;       // gate inputs per steering AND
  // inverted gate positions in the mixed-polarity variant
  localparam logic [2:0] INV_MASK = 3'h3;   // gates a and b inverted
  localparam logic [2:0] NO_MASK  = 3'h0;   // all gates taken as they are

  // ****************************************
  // reset values
  // ****************************************
  localparam logic Q_RST      = 1'h0;       // true output after RESET
  localparam logic MASTER_RST = 1'h0;       // master stage after RESET
  localparam logic CLK_RST    = 1'h0;       // last seen clock level

  // ****************************************
  // clocked actions, gray coded along hold-clear-toggle-set
  // ****************************************
  typedef enum logic [1:0] {
    JKG_HOLD   = 2'h0,
    JKG_CLEAR  = 2'h1,
    JKG_TOGGLE = 2'h3,
    JKG_SET    = 2'h2
  } jkg_action_t;

endpackage

// File: src/jkg_steer.sv
// gating of the set and clear steering inputs
`timescale 1ns/1ps
module jkg_steer #(
  parameter logic [2:0] MASK = 3'h0
) (
  // gate inputs
  input  wire logic [2:0] set_gates,
  input  wire logic [2:0] clear_gates,
  // steering values
  output wire logic       set_steer,
  output wire logic       clear_steer
);

  // selected gates inverted, the rest used plainly, then ANDed
  wire logic [2:0] set_eff;
  wire logic [2:0] clear_eff;
  assign set_eff     = set_gates ^ MASK;
  assign clear_eff   = clear_gates ^ MASK;
  assign set_steer   = &set_eff;
  assign clear_steer = &clear_eff;

endmodule // jkg_steer

// File: src/jkg_flop.sv
// gated master-slave j-k flip-flop with asynchronous preset and clear
//
// Notes on behaviour
// - set steering is AND of three set gates, clear likewise.
// - a variant inverts some gate inputs before each AND.
// - steering values load a master stage separate from the slave.
// - outside RESET, preset and clear, outputs change only at a rising flip-flop clock edge.
// - hold, clear, set or toggle; complement always the inverse.
// - clocked operation only while preset and clear are both low.
// - active-high asynchronous preset and clear override steering.
`timescale 1ns/1ps
module jkg_flop
  import jkg_pkg::*;
#(
  parameter bit MIXED_VARIANT = 1'b0  // 1 selects inverted-gate variant
) (
  // system clock and reset
  input  wire logic                    REF_CLK,
  input  wire logic                    RESET,
  // flip-flop clock, sampled on REF_CLK
  input  wire logic                    JK_CLK,
  // gate inputs, index 0..2 are gates a..c
  input  wire logic [jkg_pkg::GATE_W-1:0] SET_GATE,
  input  wire logic [jkg_pkg::GATE_W-1:0] CLEAR_GATE,
  // asynchronous overrides
  input  wire logic                    PRESET,
  input  wire logic                    CLEAR,
  // outputs
  output logic                         Q,
  output logic                         Q_N
);

  import jkg_pkg::*;

  // ****************************************
  // steering
  // ****************************************
  localparam logic [2:0] MASK = MIXED_VARIANT ? INV_MASK : NO_MASK;

  logic set_steer;
  logic clear_steer;

  jkg_steer #(
    .MASK        (MASK)
  ) u_steer (
    .set_gates   (SET_GATE),
    .clear_gates (CLEAR_GATE),
    .set_steer   (set_steer),
    .clear_steer (clear_steer)
  );

  // maps steering pair to the clocked action
  function automatic jkg_action_t action_of(input logic s, input logic c);
    jkg_action_t a;
    a = JKG_HOLD;
    if (s && c) begin
      a = JKG_TOGGLE;
    end else if (s) begin
      a = JKG_SET;
    end else if (c) begin
      a = JKG_CLEAR;
    end
    return a;
  endfunction

  // next true value for an action on the present state
  function automatic logic next_q(input jkg_action_t a, input logic q);
    logic n;
    n = q;
    case (a)
      JKG_HOLD:   n = q;
      JKG_CLEAR:  n = 1'b0;
      JKG_TOGGLE: n = ~q;
      JKG_SET:    n = 1'b1;
      default:    n = q;
    endcase
    return n;
  endfunction

  // ****************************************
  // master and slave stages
  // ****************************************
  logic        clk_prev_r;
  logic        master_r;
  logic        master_nxt;
  logic        q_r;
  logic        qn_r;
  wire logic   jk_rise;
  wire logic   async_on;
  jkg_action_t action;

  // edge detect on the sampled flip-flop clock
  assign jk_rise  = JK_CLK & ~clk_prev_r;
  assign async_on = PRESET | CLEAR;
  assign action   = action_of(set_steer, clear_steer);
  assign master_nxt = next_q(action, q_r);

  // last clock level, for the edge detect
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      clk_prev_r <= CLK_RST;
    end else begin
      clk_prev_r <= JK_CLK;
    end
  end

  always_ff @(posedge REF_CLK or posedge PRESET or posedge CLEAR) begin
    if (CLEAR) begin
      master_r <= 1'b0;
    end else if (PRESET) begin
      master_r <= 1'b1;
    end else if (RESET) begin
      master_r <= MASTER_RST;
    end else if (!JK_CLK) begin
      master_r <= master_nxt;
    end
  end

  // clocked load only when overrides low
  always_ff @(posedge REF_CLK or posedge PRESET or posedge CLEAR) begin
    if (CLEAR) begin
      q_r  <= 1'b0;
      qn_r <= 1'b1;
    end else if (PRESET) begin
      q_r  <= 1'b1;
      qn_r <= 1'b0;
    end else if (RESET) begin
      q_r  <= Q_RST;
      qn_r <= ~Q_RST;
    end else if (jk_rise) begin
      q_r  <= master_r;
      qn_r <= ~master_r;
    end
  end

  // outputs straight from the slave flops
  assign Q   = q_r;
  assign Q_N = qn_r;

  // ****************************************
  // checks
  // ****************************************
  // steering checks
  steer_and_a :
    assert property (@(posedge REF_CLK) disable iff (RESET)
      set_steer == (SET_GATE == (MASK ^ 3'h7))
        && clear_steer == (CLEAR_GATE == (MASK ^ 3'h7)))
    else $error("steering value does not match gate AND");

  variant_inv_a :
    assert property (@(posedge REF_CLK) disable iff (RESET)
      (SET_GATE == 3'h7) |-> set_steer == (MASK == 3'h0))
    else $error("inverted gates not treated as variant requires");

  // clocked path checks
  master_frozen_a :
    assert property (@(posedge REF_CLK)
      disable iff (RESET || PRESET || CLEAR)
      JK_CLK |=> $stable(master_r))
    else $error("master changed while flip-flop clock high");

  edge_only_a :
    assert property (@(posedge REF_CLK)
      disable iff (RESET || PRESET || CLEAR)
      !jk_rise |=> $stable(Q) && $stable(Q_N))
    else $error("output changed without a rising clock edge");

  toggle_step_a :
    assert property (@(posedge REF_CLK)
      disable iff (RESET || PRESET || CLEAR)
      (!JK_CLK && set_steer && clear_steer) ##1 (JK_CLK && jk_rise)
        |=> Q != $past(Q))
    else $error("both steering high did not toggle");

  set_clear_a :
    assert property (@(posedge REF_CLK)
      disable iff (RESET || PRESET || CLEAR)
      (!JK_CLK && (set_steer != clear_steer)) ##1 jk_rise
        |=> Q == $past(set_steer, 2))
    else $error("single steering value not applied at edge");

  hold_step_a :
    assert property (@(posedge REF_CLK)
      disable iff (RESET || PRESET || CLEAR)
      (!JK_CLK && !set_steer && !clear_steer) ##1 jk_rise
        |=> $stable(Q))
    else $error("both steering low did not hold");

  // complement check
  compl_out_a :
    assert property (@(posedge REF_CLK) disable iff (RESET)
      Q_N == ~Q)
    else $error("complement output not inverse of true output");

  // override check: first rise after preset release moves the forced high value
  no_clocked_a :
    assert property (@(posedge REF_CLK) disable iff (RESET || CLEAR)
      (PRESET && !CLEAR) ##1 (!PRESET && !CLEAR && jk_rise)
        |=> Q && master_r)
    else $error("release of preset let a stale clocked load through");

  // forced state checks
  preset_force_a :
    assert property (@(posedge REF_CLK) disable iff (RESET)
      (PRESET && !CLEAR) |-> Q && !Q_N)
    else $error("preset did not force true output high");

  preset_master_a :
    assert property (@(posedge REF_CLK) disable iff (RESET)
      (PRESET && !CLEAR) |-> master_r)
    else $error("preset did not force the master stage high");

  clear_force_a :
    assert property (@(posedge REF_CLK) disable iff (RESET)
      CLEAR |-> !Q && Q_N && !master_r)
    else $error("clear did not force true output low");

endmodule // jkg_flop

// File: dv/jkg_far.sv
// far-side logic driving the flop clock and gates
`timescale 1ns/1ps
module jkg_far (
  // clock and enable
  input  wire logic       clk,
  input  wire logic       run,
  // wanted gate values
  input  wire logic [2:0] sg,
  input  wire logic [2:0] cg,
  // drives to the flop
  output logic            jk,
  output wire logic [2:0] sg_o,
  output wire logic [2:0] cg_o
);
  // flop clock held low until run, then one cycle high, one low
  initial jk = 1'b0;
  always @(negedge clk) jk <= run & ~jk;
  // gates garbled while the flop clock is high
  assign sg_o = jk ? ~sg : sg;
  assign cg_o = jk ? ~cg : cg;
endmodule // jkg_far

// File: dv/test_gated_jk_flip_flop.sv
// self-checking bench for the gated j-k flip-flop
`timescale 1ns/1ps
module test_gated_jk_flip_flop;
  import jkg_pkg::*;
  logic       REF_CLK, RESET, PRESET, CLEAR, run, jk;
  logic [2:0] sg, cg, sgw, cgw;
  logic       q0, qn0, q1, qn1, e0, e1;
  int         n_errors, n_tests;
  jkg_far far (.clk(REF_CLK), .run(run), .sg(sg), .cg(cg),
    .jk(jk), .sg_o(sgw), .cg_o(cgw));
  jkg_flop #(.MIXED_VARIANT(1'b0)) dut (.REF_CLK(REF_CLK),
    .RESET(RESET), .JK_CLK(jk), .SET_GATE(sgw), .CLEAR_GATE(cgw),
    .PRESET(PRESET), .CLEAR(CLEAR), .Q(q0), .Q_N(qn0));
  jkg_flop #(.MIXED_VARIANT(1'b1)) dut_mix (.REF_CLK(REF_CLK),
    .RESET(RESET), .JK_CLK(jk), .SET_GATE(sgw), .CLEAR_GATE(cgw),
    .PRESET(PRESET), .CLEAR(CLEAR), .Q(q1), .Q_N(qn1));
  // 40 MHz clock
  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  // expected next state from gates and polarity mask
  function automatic logic nxt(logic q, logic [2:0] s, logic [2:0] c,
                               logic [2:0] m);
    case ({&(s ^ m), &(c ^ m)})
      2'h0: nxt = q;
      2'h1: nxt = 1'b0;
      2'h2: nxt = 1'b1;
      default: nxt = ~q;
    endcase
  endfunction
  task automatic check(logic seen, logic want);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %b, want %b", $time, seen, want);
    end
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // both variants against the model
  task automatic both_chk;
    check(q0, e0);
    check(qn0, ~e0);
    check(q1, e1);
    check(qn1, ~e1);
  endtask
  // one clocked operation, checked after its rise
  task automatic op(logic [2:0] s, logic [2:0] c);
    @(negedge REF_CLK);
    if (jk !== 1'b1) @(negedge REF_CLK);
    both_chk();
    sg = s;
    cg = c;
    e0 = nxt(e0, s, c, NO_MASK);
    e1 = nxt(e1, s, c, INV_MASK);
    @(negedge REF_CLK);
  endtask
  task automatic force_q(logic p, logic c);
    @(negedge REF_CLK);
    both_chk();
    sg = 3'h7;
    cg = 3'h7;
    PRESET = p;
    CLEAR = c;
    e0 = p & ~c;
    e1 = e0;
    #1;
    check(q0, e0);
    check(q1, e1);
    repeat (6) @(negedge REF_CLK);
    // release just before a flop clock rise
    if (jk !== 1'b0) @(negedge REF_CLK);
    both_chk();
    // overrides low again for clocked operation
    PRESET = 1'b0;
    CLEAR = 1'b0;
    sg = 3'h0;
    cg = 3'h0;
  endtask
  // mid-run reset puts the stored state back to its reset value
  task automatic reset_mid;
    @(negedge REF_CLK);
    both_chk();
    RESET = 1'b1;
    sg = 3'h0;
    cg = 3'h0;
    e0 = Q_RST;
    e1 = Q_RST;
    repeat (2) @(negedge REF_CLK);
    both_chk();
    RESET = 1'b0;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    RESET = 1'b1;
    PRESET = 1'b0;
    CLEAR = 1'b0;
    run = 1'b0;
    sg = 3'h0;
    cg = 3'h0;
    e0 = Q_RST;
    e1 = Q_RST;
    n_errors = 0;
    n_tests = 0;
    void'($urandom(32'h44CF));
    repeat (6) @(negedge REF_CLK);
    RESET = 1'b0;
    both_chk();
    run <= 1'b1;
    for (int i = 0; i < 8; i++)
      op(i[0] ? (i[2] ? 3'h4 : 3'h7) : 3'h0,
         i[1] ? (i[2] ? 3'h4 : 3'h7) : 3'h0);
    force_q(1'b0, 1'b1);
    force_q(1'b1, 1'b1);
    force_q(1'b1, 1'b0);
    // random gates, garbled while clock high
    repeat (60) op(3'($urandom), 3'($urandom));
    op(3'h7, 3'h0);
    reset_mid();
    op(3'h0, 3'h0);
    final_report();
  end
  // watchdog
  initial begin
    #(25 * 3000);
    n_errors++;
    final_report();
  end
endmodule // test_gated_jk_flip_flop
